// [common/dtp_pkg.sv]
`default_nettype none
// shared constants and types of the duty and tone pulse port
package dtp_pkg;

    // latch layout
    localparam int LATCH_W       = 4;
    localparam int DATA_W        = 6;
    localparam int MODE_LSB_POS  = 0;
    localparam int MODE_MSB_POS  = 1;
    localparam int LOW_DATA_POS  = 2;
    localparam int LOW_DATA_TOP  = 3;
    localparam logic [LATCH_W-1:0] LATCH_RST = 4'h0;

    // mode selector codes
    localparam logic [1:0] MODE_STATIC = 2'h0;
    localparam logic [1:0] MODE_DUTY   = 2'h2;
    localparam int         MODE_SG_BIT = 0;
    localparam int         MODE_FB_BIT = 1;

    // latch select values on the core port
    localparam logic LATCH_SEL_LOW  = 1'b0;
    localparam logic LATCH_SEL_HIGH = 1'b1;

    // timing: clock rate and documented output rates
    localparam int CLK_HZ        = 50_000_000;
    localparam int DUTY_RATE_HZ  = 2690;
    localparam int DUTY_SLOTS    = 67;
    localparam int DUTY_OFFSET   = 2;
    localparam int BASE_LOW_HZ   = 18_000;
    localparam int BASE_HIGH_HZ  = 180_000;
    localparam int SG_OFFSET     = 2;

    // derived cycle counts, rounded down, never below one
    localparam int DUTY_SLOT_CYC = (CLK_HZ / (DUTY_RATE_HZ * DUTY_SLOTS)) > 0 ?
                                   (CLK_HZ / (DUTY_RATE_HZ * DUTY_SLOTS)) : 1;
    localparam int BASE_LOW_CYC  = (CLK_HZ / BASE_LOW_HZ) > 0 ? (CLK_HZ / BASE_LOW_HZ) : 1;
    localparam int BASE_HIGH_CYC = (CLK_HZ / BASE_HIGH_HZ) > 0 ? (CLK_HZ / BASE_HIGH_HZ) : 1;
    localparam int PRE_W         = 12;
    localparam int SLOT_W        = 7;

    // kind of write access from the core
    typedef enum logic [1:0] {
        DTP_ACC_WRITE,
        DTP_ACC_BIT_SET,
        DTP_ACC_BIT_RESET,
        DTP_ACC_NONE
    } dtp_acc_kind_t;

    // one core access to a latch
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic                sel;
        dtp_acc_kind_t       kind;
        logic [LATCH_W-1:0]  data;
    } dtp_core_req_t;

    // read answer to the core
    typedef struct packed {
        logic                valid;
        logic [LATCH_W-1:0]  data;
    } dtp_core_rsp_t;

endpackage
`default_nettype wire

// [design/dtp_pulse_port.sv]
`default_nettype none

// Contract
// RULE_01 - low latch bits 1..0 select mode
// RULE_02 - data: high latch MSB, low bit2 LSB
// RULE_03 - latch reads return content, no effect
// RULE_04 - powerup or clock stop: pin low
// RULE_05 - any low latch write activates output; here a low write while clock stop is set stores but leaves the pin idle
// RULE_06 - high latch write alone never activates
// RULE_07 - chip enable changes leave pin alone
// RULE_08 - software clears low latch for low
// RULE_09 - mode 00 drives low bit 2
// RULE_10 - static mode ignores other data bits
// RULE_11 - mode 10 emits 2.69 kHz pulses
// RULE_12 - 67 slots, high for data+2
// RULE_13 - software writes high latch first
// RULE_14 - running duty takes new high data
// RULE_15 - mode bit0 set gives square wave
// RULE_16 - frequency base over 2(data+2)
// RULE_17 - mode bit1 picks 18k or 180k
// RULE_18 - square wave starts on low write
// RULE_19 - toggle after data+2 base ticks
// RULE_20 - free modulo-67 slot counter compare
module dtp_pulse_port (
    input  wire logic           sys_clk_i,
    input  wire logic           sys_rst_i,
    input  wire logic           clk_en_i,
    input  wire logic           clock_stop_i,
    input  wire logic           chip_enable_pin_i,
    input  wire dtp_pkg::dtp_core_req_t core_req_i,
    output var  dtp_pkg::dtp_core_rsp_t core_rsp_o,
    output logic                chip_enable_level_o,
    output logic                pulse_output_active_o,
    output logic                pulse_output_pin_o
);
    import dtp_pkg::*;

    // output generator states
    typedef enum logic [1:0] {
        DTP_IDLE,
        DTP_STATIC,
        DTP_DUTY,
        DTP_TONE
    } dtp_gen_state_t;

    // latches and generator state
    logic [LATCH_W-1:0] control_low_latch;
    logic [LATCH_W-1:0] data_high_latch;
    logic [LATCH_W-1:0] next_low_latch;
    logic [LATCH_W-1:0] next_high_latch;
    dtp_gen_state_t     gen_state;
    dtp_gen_state_t     next_gen_state;
    logic [1:0]         mode_selector_bits;
    logic [DATA_W-1:0]  data_value;
    logic               low_write;
    logic               high_write;
    logic               halt;

    // duty generator
    logic [PRE_W-1:0]   duty_pre;
    logic [SLOT_W-1:0]  duty_slot;
    logic               duty_tick;
    logic               duty_level;

    // tone generator
    logic [PRE_W-1:0]   tone_pre;
    logic [SLOT_W-1:0]  tone_cnt;
    logic               tone_tick;
    logic               tone_level;
    logic [PRE_W-1:0]   tone_base_cyc;

    // chip enable synchroniser
    logic               ce_meta;
    logic               ce_sync;

    // apply a write, bit-set or bit-reset to a latch value
    // a mask of zero still counts as a write, which is how software re-arms the pin
    function automatic logic [LATCH_W-1:0] apply_access(
        input logic [LATCH_W-1:0] old_val,
        input dtp_acc_kind_t      kind,
        input logic [LATCH_W-1:0] wdata
    );
        logic [LATCH_W-1:0] res;
        res = old_val;
        case (kind)
            DTP_ACC_WRITE:     res = wdata;
            DTP_ACC_BIT_SET:   res = old_val | wdata;
            DTP_ACC_BIT_RESET: res = old_val & ~wdata;
            default:           res = old_val;
        endcase
        return res;
    endfunction

    // generator state that a mode code selects
    // codes x1 both give the tone, 00 static and 10 duty
    function automatic dtp_gen_state_t mode_to_state(input logic [1:0] mode);
        dtp_gen_state_t st;
        st = DTP_STATIC;
        if (mode[MODE_SG_BIT]) begin
            st = DTP_TONE;
        end else if (mode == MODE_DUTY) begin
            st = DTP_DUTY;
        end else begin
            st = DTP_STATIC;
        end
        return st;
    endfunction

    // count compare against data plus an offset, widened to avoid overflow
    function automatic logic below_data(
        input logic [SLOT_W-1:0] cnt,
        input logic [DATA_W-1:0] dat,
        input int                offset
    );
        logic [SLOT_W-1:0] limit;
        limit = SLOT_W'(dat) + SLOT_W'(offset);
        return cnt < limit;
    endfunction

    // a write access that changes or touches the named latch
    function automatic logic is_latch_write(
        input dtp_core_req_t req,
        input logic          sel
    );
        return req.wr && (req.sel == sel) && (req.kind != DTP_ACC_NONE);
    endfunction

    // decode of core strobes; writes under clock stop still store
    // clock stop is a same-clock level from the core, so no synchroniser
    assign halt       = clock_stop_i;
    assign low_write  = is_latch_write(core_req_i, LATCH_SEL_LOW);
    assign high_write = is_latch_write(core_req_i, LATCH_SEL_HIGH);

    // RULE_01 mode from latch
    assign mode_selector_bits = control_low_latch[MODE_MSB_POS:MODE_LSB_POS];
    // RULE_02 data bit assembly
    assign data_value = {data_high_latch, control_low_latch[LOW_DATA_TOP:LOW_DATA_POS]};

    // next latch values from the current access
    always_comb begin
        next_low_latch  = control_low_latch;
        next_high_latch = data_high_latch;
        if (low_write) begin
            next_low_latch = apply_access(control_low_latch, core_req_i.kind, core_req_i.data);
        end
        if (high_write) begin
            next_high_latch = apply_access(data_high_latch, core_req_i.kind, core_req_i.data);
        end
    end

    // low latch storage; clock stop keeps contents
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            // latches come up zero, a defined stand-in for the undefined power-up value
            control_low_latch <= LATCH_RST;
        end else if (clk_en_i) begin
            // RULE_04 contents kept
            control_low_latch <= next_low_latch;
        end
    end

    // high latch storage; clock stop keeps contents
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            data_high_latch <= LATCH_RST;
        end else if (clk_en_i) begin
            // RULE_04 contents kept
            data_high_latch <= next_high_latch;
        end
    end

    // RULE_03 read back latch
    // read data holds until the next read so the core may take it late
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            core_rsp_o <= '0;
        end else if (clk_en_i) begin
            core_rsp_o.valid <= core_req_i.rd;
            if (core_req_i.rd) begin
                core_rsp_o.data <= (core_req_i.sel == LATCH_SEL_HIGH) ?
                                   data_high_latch : control_low_latch;
            end
        end
    end

    // generator state: only a low latch write activates
    // clock stop wins over a low write in the same cycle, so the pin cannot
    // leave the stopped state before the stop is lifted
    always_comb begin
        next_gen_state = gen_state;
        if (halt) begin
            // RULE_04 stop goes idle
            next_gen_state = DTP_IDLE;
        end else if (low_write) begin
            // RULE_05 low write activates
            next_gen_state = mode_to_state(next_low_latch[MODE_MSB_POS:MODE_LSB_POS]);
        end
        // RULE_06 high write ignored here
    end

    // generator state register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gen_state <= DTP_IDLE;
        end else if (clk_en_i) begin
            gen_state <= next_gen_state;
        end
    end

    // RULE_20 slot prescaler
    assign duty_tick = (duty_pre == PRE_W'(DUTY_SLOT_CYC - 1));
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            duty_pre <= '0;
        end else if (clk_en_i) begin
            duty_pre <= duty_tick ? '0 : duty_pre + PRE_W'(1);
        end
    end

    // RULE_12 modulo 67 slots
    // free running: a new duty write joins the period in progress, so the
    // first period after activation may be cut short
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            duty_slot <= '0;
        end else if (clk_en_i && duty_tick) begin
            duty_slot <= (duty_slot == SLOT_W'(DUTY_SLOTS - 1)) ? '0 :
                         duty_slot + SLOT_W'(1);
        end
    end

    // RULE_14 live high data
    // data is read live, so a high latch write alone retunes a running train
    assign duty_level = below_data(duty_slot, data_value, DUTY_OFFSET);

    // RULE_17 base selection
    // base periods are rounded down in clock cycles, so tones run slightly fast
    assign tone_base_cyc = mode_selector_bits[MODE_FB_BIT] ? PRE_W'(BASE_HIGH_CYC) :
                                                              PRE_W'(BASE_LOW_CYC);
    assign tone_tick = (tone_pre >= tone_base_cyc - PRE_W'(1));

    // RULE_19 tone counters restart
    // a restart on every low write keeps the first half period whole, even
    // when the write only repeats the same mode and data
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tone_pre <= '0;
        end else if (clk_en_i) begin
            if (halt || low_write || tone_tick) begin
                tone_pre <= '0;
            end else begin
                tone_pre <= tone_pre + PRE_W'(1);
            end
        end
    end

    // half period counter and tone level
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tone_cnt   <= '0;
            tone_level <= 1'b0;
        end else if (clk_en_i) begin
            if (halt) begin
                tone_cnt   <= '0;
                tone_level <= 1'b0;
            end else if (low_write) begin
                // RULE_18 start on write
                tone_cnt   <= '0;
                tone_level <= 1'b1;
            end else if (tone_tick) begin
                // RULE_16 half period data+2
                if (!below_data(tone_cnt + SLOT_W'(1), data_value, SG_OFFSET)) begin
                    tone_cnt   <= '0;
                    tone_level <= ~tone_level;
                end else begin
                    tone_cnt <= tone_cnt + SLOT_W'(1);
                end
            end
        end
    end

    // generator activity flag, follows the state register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pulse_output_active_o <= 1'b0;
        end else if (clk_en_i) begin
            pulse_output_active_o <= (next_gen_state != DTP_IDLE);
        end
    end

    // output pin level per generator state
    // the pin is registered, so tone edges trail the tone level by one cycle;
    // a low write sets the pin high at once to cover that lag
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pulse_output_pin_o <= 1'b0;
        end else if (clk_en_i) begin
            // RULE_07 chip enable unused here
            case (next_gen_state)
                DTP_IDLE: begin
                    // RULE_04 pin forced low
                    pulse_output_pin_o <= 1'b0;
                end
                DTP_STATIC: begin
                    // RULE_09 RULE_10 bit two only
                    pulse_output_pin_o <= next_low_latch[LOW_DATA_POS];
                end
                DTP_DUTY: begin
                    // RULE_11 duty pulse train
                    pulse_output_pin_o <= duty_level;
                end
                DTP_TONE: begin
                    // RULE_15 square wave
                    pulse_output_pin_o <= low_write ? 1'b1 : tone_level;
                end
                default: begin
                    pulse_output_pin_o <= 1'b0;
                end
            endcase
        end
    end

    // chip enable synchroniser; only the second stage reads the first
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ce_meta <= 1'b0;
            ce_sync <= 1'b0;
        end else if (clk_en_i) begin
            ce_meta <= chip_enable_pin_i;
            ce_sync <= ce_meta;
        end
    end

    // chip enable level for software polling; never steers the pin
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            chip_enable_level_o <= 1'b0;
        end else if (clk_en_i) begin
            chip_enable_level_o <= ce_sync;
        end
    end

endmodule
`default_nettype wire

// [testbench/dtp_pulse_port_props.sv]
`default_nettype none
// port level checks of the pulse port
module dtp_pulse_port_props (
    input wire logic                   sys_clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   clk_en_i,
    input wire logic                   clock_stop_i,
    input wire logic                   chip_enable_pin_i,
    input wire dtp_pkg::dtp_core_req_t core_req_i,
    input wire dtp_pkg::dtp_core_rsp_t core_rsp_o,
    input wire logic                   chip_enable_level_o,
    input wire logic                   pulse_output_active_o,
    input wire logic                   pulse_output_pin_o
);
    import dtp_pkg::*;
    logic en;
    logic pin;
    logic act;
    logic low_wr;
    // short aliases and a taken plain write to the low latch
    assign en = clk_en_i;
    assign pin = pulse_output_pin_o;
    assign act = pulse_output_active_o;
    assign low_wr = en && !clock_stop_i && core_req_i.wr && core_req_i.kind == DTP_ACC_WRITE
        && core_req_i.sel == LATCH_SEL_LOW;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_stop; en && clock_stop_i |=> !pin && !act; endproperty
    a_stop: assert property (p_stop) else $error("pin not low in stop");
    property p_static; low_wr && core_req_i.data[1:0] == MODE_STATIC
        |=> pin == $past(core_req_i.data[2]); endproperty
    a_static: assert property (p_static) else $error("static level wrong");
    property p_tone; low_wr && core_req_i.data[MODE_SG_BIT] |=> pin && act; endproperty
    a_tone: assert property (p_tone) else $error("tone did not start");
    property p_high; en && core_req_i.wr && core_req_i.sel == LATCH_SEL_HIGH && !act
        |=> !act; endproperty
    a_high: assert property (p_high) else $error("high write activated");
    property p_rd; en && core_req_i.rd |=> core_rsp_o.valid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_hold; en && !core_req_i.rd |=> !core_rsp_o.valid && $stable(core_rsp_o.data);
    endproperty
    a_hold: assert property (p_hold) else $error("answer changed unasked");
    property p_cause; $changed(pin) |-> $past(act || core_req_i.wr || clock_stop_i); endproperty
    a_cause: assert property (p_cause) else $error("pin changed without cause");
    property p_ce; $stable(chip_enable_pin_i) [*5] |=> chip_enable_level_o == $past(chip_enable_pin_i);
    endproperty
    a_ce: assert property (p_ce) else $error("enable level wrong");
endmodule
bind dtp_pulse_port dtp_pulse_port_props u_props (.sys_clk_i, .sys_rst_i, .clk_en_i,
    .clock_stop_i, .chip_enable_pin_i, .core_req_i, .core_rsp_o, .chip_enable_level_o,
    .pulse_output_active_o, .pulse_output_pin_o);
`default_nettype wire

// [testbench/dtp_pulse_port_tb.sv]
`default_nettype none
// latch access sequences with pin timing checks
module dtp_pulse_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dtp_pkg::*;
    localparam logic [3:0]  TONE_LOW [3]  = '{4'h3, 4'h7, 4'h1};
    localparam logic [15:0] TONE_HALF [3] = '{16'(2 * BASE_HIGH_CYC), 16'(3 * BASE_HIGH_CYC),
                                              16'(2 * BASE_LOW_CYC)};
    logic          sys_clk_i, sys_rst_i, clk_en_i, clock_stop_i, chip_enable_pin_i;
    logic          chip_enable_level_o, pulse_output_active_o, pulse_output_pin_o;
    dtp_core_req_t core_req_i;
    dtp_core_rsp_t core_rsp_o;
    int            miscompares = 0;
    int            comparisons = 0;
    int            hi;
    int            lo;
    dtp_pulse_port dut (.sys_clk_i, .sys_rst_i, .clk_en_i, .clock_stop_i, .chip_enable_pin_i,
        .core_req_i, .core_rsp_o, .chip_enable_level_o, .pulse_output_active_o,
        .pulse_output_pin_o);
    // clock
    initial begin
        sys_clk_i = 1'h0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // compare and count
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // one latch access, then an idle cycle
    task automatic acc(input logic r, input logic s, input dtp_acc_kind_t k, input logic [3:0] d);
        @(posedge sys_clk_i);
        core_req_i <= {~r, r, s, k, d};
        @(posedge sys_clk_i);
        core_req_i <= '0;
        #1;
    endtask
    // read a latch and compare the answer
    task automatic rd(input logic s, input logic [3:0] e);
        acc(1'h1, s, DTP_ACC_WRITE, 4'h0);
        chk("read valid", 16'(core_rsp_o.valid), 16'h1);
        chk("read data", 16'(core_rsp_o.data), 16'(e));
    endtask
    // count cycles while the pin holds a level
    task automatic run(input logic lvl, output int c);
        c = 0;
        while (pulse_output_pin_o === lvl && c < 40000) begin
            @(posedge sys_clk_i);
            #1;
            c++;
        end
    endtask
    // skip the current phase and any low phase after it, then time one high and one low phase
    task automatic measure();
        int n;
        run(1'h1, n);
        run(1'h0, n);
        run(1'h1, hi);
        run(1'h0, lo);
    endtask
    // verdict
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // cuts a hang short
    initial begin
        #2_500_000;
        miscompares++;
        finish_test();
    end
    // main sequence
    initial begin
        sys_rst_i = 1'h1;
        clk_en_i = 1'h1;
        clock_stop_i = 1'h0;
        chip_enable_pin_i = 1'h0;
        core_req_i = '0;
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'h0;
        #1;
        chk("reset pin", 16'(pulse_output_pin_o), 16'h0);
        acc(1'h0, LATCH_SEL_HIGH, DTP_ACC_WRITE, 4'hF);
        chk("high inert", 16'(pulse_output_active_o), 16'h0);
        rd(LATCH_SEL_HIGH, 4'hF);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_WRITE, 4'hC);
        chk("static one", 16'(pulse_output_pin_o), 16'h1);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_WRITE, 4'h8);
        chk("static zero", 16'(pulse_output_pin_o), 16'h0);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_WRITE, 4'h4);
        // a frozen block takes no write
        @(posedge sys_clk_i);
        clk_en_i <= 1'h0;
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_WRITE, 4'h0);
        chk("frozen pin", 16'(pulse_output_pin_o), 16'h1);
        @(posedge sys_clk_i);
        clk_en_i <= 1'h1;
        rd(LATCH_SEL_LOW, 4'h4);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk_i);
            chip_enable_pin_i <= ~chip_enable_pin_i;
            repeat (6) @(posedge sys_clk_i);
            #1;
            chk("ce level", 16'(chip_enable_level_o), 16'(chip_enable_pin_i));
            chk("ce pin", 16'(pulse_output_pin_o), 16'h1);
        end
        @(posedge sys_clk_i);
        clock_stop_i <= 1'h1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("stop pin", 16'(pulse_output_pin_o), 16'h0);
        @(posedge sys_clk_i);
        clock_stop_i <= 1'h0;
        rd(LATCH_SEL_LOW, 4'h4);
        chk("read inert", 16'(pulse_output_pin_o), 16'h0);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_BIT_SET, 4'h0);
        chk("empty set", 16'(pulse_output_pin_o), 16'h1);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_BIT_RESET, 4'h7);
        chk("cleared", 16'(pulse_output_pin_o), 16'h0);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_NONE, 4'hF);
        rd(LATCH_SEL_LOW, 4'h0);
        acc(1'h0, LATCH_SEL_HIGH, DTP_ACC_WRITE, 4'hB);
        acc(1'h0, LATCH_SEL_LOW, DTP_ACC_WRITE, 4'h6);
        chk("duty on", 16'(pulse_output_active_o), 16'h1);
        measure();
        chk("duty high", 16'(hi), 16'(47 * DUTY_SLOT_CYC));
        chk("duty low", 16'(lo), 16'(20 * DUTY_SLOT_CYC));
        acc(1'h0, LATCH_SEL_HIGH, DTP_ACC_WRITE, 4'h0);
        measure();
        chk("new high", 16'(hi), 16'(3 * DUTY_SLOT_CYC));
        chk("new low", 16'(lo), 16'(64 * DUTY_SLOT_CYC));
        for (int i = 0; i < 3; i++) begin
            acc(1'h0, LATCH_SEL_LOW, DTP_ACC_WRITE, TONE_LOW[i]);
            chk("tone start", 16'(pulse_output_pin_o), 16'h1);
            measure();
            chk("tone high", 16'(hi), TONE_HALF[i]);
            chk("tone low", 16'(lo), TONE_HALF[i]);
        end
        finish_test();
    end
endmodule
`default_nettype wire
